// ===== design/slb_pkg.sv
// Constants, types and field layouts for the strap latch and boot selector.
// Assumes one 125 MHz core clock and an APB register port on that clock.
package slb_pkg;

  // ==========================================================================
  // Timing.
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned STRAP_HOLD_NS = 1000;
  localparam int unsigned HOLD_CYC =
    (STRAP_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned HOLD_W = 8;
  localparam logic [HOLD_W-1:0] HOLD_LAST = HOLD_W'(HOLD_CYC - 1);

  // ==========================================================================
  // Strap bundle, primary boot strap in bit 0.
  typedef struct packed {
    logic dbg_src;
    logic supply;
    logic sec_boot;
    logic pri_boot;
  } slb_straps_t;

  localparam logic [3:0] PULL_UP_MASK  = 4'h1;
  localparam logic [3:0] PULL_DN_MASK  = 4'h6;
  localparam logic [3:0] STRAP_DEFAULT = 4'h1;

  // ==========================================================================
  // Decoded settings.
  typedef enum logic [1:0] {
    BOOT_FLASH    = 2'h0,
    BOOT_DOWNLOAD = 2'h1,
    BOOT_INVALID  = 2'h2
  } slb_boot_t;

  typedef enum logic [1:0] {
    DBG_USB  = 2'h0,
    DBG_PADS = 2'h1,
    DBG_OFF  = 2'h2
  } slb_dbg_t;

  typedef enum logic [2:0] {
    ST_OFF  = 3'h1,
    ST_HOLD = 3'h2,
    ST_RUN  = 3'h4
  } slb_state_t;

  // ==========================================================================
  // Register map and status layout.
  localparam logic [7:0] REG_STATUS   = 8'h00;
  localparam logic [7:0] REG_GPIO_OUT = 8'h04;
  localparam logic [7:0] REG_GPIO_OE  = 8'h08;
  localparam logic [7:0] REG_GPIO_IN  = 8'h0C;
  localparam int unsigned ST_STRAP_LSB = 0;
  localparam int unsigned ST_BOOT_LSB  = 4;
  localparam int unsigned ST_V18_BIT   = 6;
  localparam int unsigned ST_DBG_LSB   = 7;
  localparam int unsigned ST_VALID_BIT = 9;
  localparam logic [31:0] ZERO_WORD    = 32'h0000_0000;

endpackage

// ===== design/slb_strap_latch.sv
// Strap latch, boot decode and strap pin release with an APB register port.
// Assumes all inputs synchronous to core_clk_in; pad pulls resolve outside.
// What this block does
// - Active only while power-up pin is high.
// - Configuration comes from the four strap inputs.
// - Weak pulls give defaults 1,0,0 during reset.
// - Undriven boot or supply strap reads its weak pull value.
// - Each strap has a latch sampled at reset.
// - Latched straps never change until power-down.
// - After sampling, strap pins become plain IO.
// - Sample during hold interval, then release pins.
// - Primary 1 flash boot; both 0 download.
// - Supply strap picks 3.3 V or 1.8 V unless the override fuse is set.
// - Debug strap plus fuses pick debug source.
`timescale 1ns/1ps

module slb_strap_latch
  import slb_pkg::*;
(
  // Clock and reset.
  input  wire logic                 core_clk_in,
  input  wire logic                 rst_n_in,
  // Power-up and reset pin.
  input  wire logic                 power_up_reset_pin_in,
  // Strap pads.
  input  wire slb_pkg::slb_straps_t strap_pad_in,
  output logic [3:0]                strap_pad_out,
  output logic [3:0]                strap_pad_oe_out,
  output logic [3:0]                strap_pull_up_out,
  output logic [3:0]                strap_pull_dn_out,
  // Fuses.
  input  wire logic                 flash_supply_override_fuse_in,
  input  wire logic                 flash_supply_tieh_fuse_in,
  input  wire logic                 dbg_dis_pad_fuse_in,
  input  wire logic                 dbg_dis_usb_fuse_in,
  input  wire logic                 dbg_strap_sel_fuse_in,
  // Results.
  output logic                      chip_active_out,
  output logic                      config_valid_out,
  output slb_pkg::slb_straps_t      straps_out,
  output slb_pkg::slb_boot_t        boot_mode_out,
  output logic                      flash_supply_1v8_out,
  output logic                      rom_msg_sel_out,
  output slb_pkg::slb_dbg_t         dbg_src_out,
  // APB slave.
  input  wire logic                 psel_in,
  input  wire logic                 penable_in,
  input  wire logic                 pwrite_in,
  input  wire logic [7:0]           paddr_in,
  input  wire logic [31:0]          pwdata_in,
  output logic [31:0]               prdata_out,
  output logic                      pready_out,
  output logic                      pslverr_out
);
  import slb_pkg::*;

  // ==========================================================================
  // Decode functions.
  function automatic slb_boot_t boot_of(input slb_straps_t s);
    if (s.pri_boot)
      boot_of = BOOT_FLASH;
    else if (!s.sec_boot)
      boot_of = BOOT_DOWNLOAD;
    else
      boot_of = BOOT_INVALID;
  endfunction

  function automatic logic v18_of(input slb_straps_t s, input logic ovr,
                                  input logic tieh);
    v18_of = ovr ? !tieh : s.supply;
  endfunction

  function automatic slb_dbg_t dbg_of(input slb_straps_t s, input logic pad,
                                      input logic usb, input logic sel);
    unique case ({pad, usb})
      2'h0:    dbg_of = (sel && !s.dbg_src) ? DBG_PADS : DBG_USB;
      2'h1:    dbg_of = DBG_PADS;
      2'h2:    dbg_of = DBG_USB;
      default: dbg_of = DBG_OFF;
    endcase
  endfunction

  // ==========================================================================
  // Power sequencing.
  slb_state_t        state_ff;
  slb_state_t        nxt_state;
  logic [HOLD_W-1:0] hold_cnt_ff;
  logic              hold_done;

  assign hold_done = (hold_cnt_ff == HOLD_LAST);

  always_comb
  begin
    nxt_state = state_ff;
    if (!power_up_reset_pin_in)
      nxt_state = ST_OFF;
    else
    begin
      unique case (state_ff)
        ST_OFF:  nxt_state = ST_HOLD;
        ST_HOLD: nxt_state = hold_done ? ST_RUN : ST_HOLD;
        ST_RUN:  nxt_state = ST_RUN;
        default: nxt_state = ST_OFF;
      endcase
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      state_ff <= ST_OFF;
    else
      state_ff <= nxt_state;
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      hold_cnt_ff <= '0;
    else if (state_ff != ST_HOLD)
      hold_cnt_ff <= '0;
    else if (!hold_done)
      hold_cnt_ff <= hold_cnt_ff + HOLD_W'(1);
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      chip_active_out <= 1'b0;
    else
      chip_active_out <= power_up_reset_pin_in;
  end

  // ==========================================================================
  // Strap latches and decode.
  logic sample_now;
  assign sample_now = (state_ff == ST_HOLD) && hold_done &&
                      power_up_reset_pin_in;

  always_ff @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      straps_out       <= slb_straps_t'(STRAP_DEFAULT);
      config_valid_out <= 1'b0;
    end
    else if (nxt_state == ST_OFF)
    begin
      straps_out       <= slb_straps_t'(STRAP_DEFAULT);
      config_valid_out <= 1'b0;
    end
    else if (sample_now)
    begin
      straps_out       <= strap_pad_in;
      config_valid_out <= 1'b1;
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      boot_mode_out        <= BOOT_FLASH;
      flash_supply_1v8_out <= 1'b0;
      rom_msg_sel_out      <= 1'b0;
      dbg_src_out          <= DBG_USB;
    end
    else if (sample_now)
    begin
      boot_mode_out        <= boot_of(strap_pad_in);
      flash_supply_1v8_out <= v18_of(strap_pad_in,
                                     flash_supply_override_fuse_in,
                                     flash_supply_tieh_fuse_in);
      rom_msg_sel_out      <= strap_pad_in.sec_boot;
      dbg_src_out          <= dbg_of(strap_pad_in, dbg_dis_pad_fuse_in,
                                     dbg_dis_usb_fuse_in,
                                     dbg_strap_sel_fuse_in);
    end
  end

  // ==========================================================================
  // Strap pads: pulls before release, general IO after it.
  logic [3:0] gpio_out_ff;
  logic [3:0] gpio_oe_ff;
  logic       released;
  assign released = (nxt_state == ST_RUN);

  always_ff @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      strap_pull_up_out <= PULL_UP_MASK;
      strap_pull_dn_out <= PULL_DN_MASK;
      strap_pad_oe_out  <= '0;
      strap_pad_out     <= '0;
    end
    else if (!released)
    begin
      strap_pull_up_out <= PULL_UP_MASK;
      strap_pull_dn_out <= PULL_DN_MASK;
      strap_pad_oe_out  <= '0;
      strap_pad_out     <= '0;
    end
    else
    begin
      strap_pull_up_out <= '0;
      strap_pull_dn_out <= '0;
      strap_pad_oe_out  <= gpio_oe_ff;
      strap_pad_out     <= gpio_out_ff;
    end
  end

  // ==========================================================================
  // APB slave, answers in the first access cycle.
  logic setup;
  logic wr_en;
  logic mapped;
  assign setup  = psel_in && !penable_in;
  assign wr_en  = psel_in && penable_in && pready_out && pwrite_in;
  assign mapped = (paddr_in == REG_STATUS) || (paddr_in == REG_GPIO_OUT) ||
                  (paddr_in == REG_GPIO_OE) || (paddr_in == REG_GPIO_IN);

  always_ff @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      gpio_out_ff <= '0;
      gpio_oe_ff  <= '0;
    end
    else if (wr_en && (paddr_in == REG_GPIO_OUT))
      gpio_out_ff <= pwdata_in[3:0];
    else if (wr_en && (paddr_in == REG_GPIO_OE))
      gpio_oe_ff  <= pwdata_in[3:0];
  end

  logic [31:0] status_word;
  always_comb
  begin
    status_word = ZERO_WORD;
    status_word[ST_STRAP_LSB +: 4] = straps_out;
    status_word[ST_BOOT_LSB +: 2]  = boot_mode_out;
    status_word[ST_V18_BIT]        = flash_supply_1v8_out;
    status_word[ST_DBG_LSB +: 2]   = dbg_src_out;
    status_word[ST_VALID_BIT]      = config_valid_out;
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      pready_out  <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out  <= ZERO_WORD;
    end
    else
    begin
      pready_out  <= setup;
      pslverr_out <= setup && !mapped;
      prdata_out  <= ZERO_WORD;
      if (setup && !pwrite_in)
      begin
        unique case (paddr_in)
          REG_STATUS:   prdata_out <= status_word;
          REG_GPIO_OUT: prdata_out <= {28'h0000000, gpio_out_ff};
          REG_GPIO_OE:  prdata_out <= {28'h0000000, gpio_oe_ff};
          REG_GPIO_IN:  prdata_out <= {28'h0000000, strap_pad_in};
          default:      prdata_out <= ZERO_WORD;
        endcase
      end
    end
  end

  // ==========================================================================
  // Assertions.
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);

  sequence s_pin_rise;
    $rose(power_up_reset_pin_in) && (state_ff == ST_OFF);
  endsequence

  sequence s_held_high;
    power_up_reset_pin_in [*8];
  endsequence

  property p_pin_low_off;
    !power_up_reset_pin_in |=> !chip_active_out && !config_valid_out;
  endproperty
  a_pin_low_off: assert property (p_pin_low_off)
    else $error("Chip active or valid while power-up pin low.");

  property p_hold_then_valid;
    s_pin_rise ##0 s_held_high |-> !config_valid_out;
  endproperty
  a_hold_then_valid: assert property (p_hold_then_valid)
    else $error("Straps latched before hold interval ended.");

  property p_valid_in_time;
    s_pin_rise |-> ##[1:130] (config_valid_out || !power_up_reset_pin_in);
  endproperty
  a_valid_in_time: assert property (p_valid_in_time)
    else $error("Straps not latched within hold interval.");

  property p_sample_value;
    $rose(config_valid_out) |-> straps_out == $past(strap_pad_in);
  endproperty
  a_sample_value: assert property (p_sample_value)
    else $error("Latched straps differ from sampled pads.");

  property p_latch_stable;
    config_valid_out && $past(config_valid_out) |-> $stable(straps_out) &&
      $stable(boot_mode_out) && $stable(dbg_src_out);
  endproperty
  a_latch_stable: assert property (p_latch_stable)
    else $error("Latched configuration changed while powered.");

  property p_boot_decode;
    config_valid_out |-> (straps_out.pri_boot ?
      boot_mode_out == BOOT_FLASH :
      (!straps_out.sec_boot ? boot_mode_out == BOOT_DOWNLOAD : 1'b1));
  endproperty
  a_boot_decode: assert property (p_boot_decode)
    else $error("Boot mode does not follow boot straps.");

  property p_supply_decode;
    config_valid_out && !flash_supply_override_fuse_in &&
      $stable(flash_supply_override_fuse_in) |->
      flash_supply_1v8_out == straps_out.supply;
  endproperty
  a_supply_decode: assert property (p_supply_decode)
    else $error("Flash supply does not follow supply strap.");

  property p_pads_released_late;
    !config_valid_out |-> strap_pad_oe_out == '0 &&
      strap_pull_up_out == PULL_UP_MASK && strap_pull_dn_out == PULL_DN_MASK;
  endproperty
  a_pads_released_late: assert property (p_pads_released_late)
    else $error("Strap pads driven or unpulled before release.");

  property p_dbg_no_pull;
    !strap_pull_up_out[3] && !strap_pull_dn_out[3];
  endproperty
  a_dbg_no_pull: assert property (p_dbg_no_pull)
    else $error("Debug strap has a pull applied.");

  property p_gpio_after_release;
    config_valid_out && $past(config_valid_out) |->
      strap_pad_oe_out == $past(gpio_oe_ff);
  endproperty
  a_gpio_after_release: assert property (p_gpio_after_release)
    else $error("Released pads do not follow IO enable register.");

endmodule

// ===== dv/slb_board_model.sv
// Board side of the strap pads: host drive, weak pulls and pad contention.
// Assumes the bench sets host drive and the power pin in the clock domain.
`timescale 1ns/1ps

module slb_board_model
(
  // Clock.
  input  wire logic                 clk_in,
  // Host drive.
  input  wire logic [3:0]           host_en_in,
  input  wire logic [3:0]           host_val_in,
  // Device pad side.
  input  wire logic [3:0]           pad_out_in,
  input  wire logic [3:0]           pad_oe_in,
  input  wire logic [3:0]           pull_up_in,
  input  wire logic [3:0]           pull_dn_in,
  // Resolved pad level.
  output slb_pkg::slb_straps_t      pad_level_out
);
  import slb_pkg::*;

  logic [3:0] float_ff = 4'h5;
  logic [3:0] lvl;

  // ========
  // Floating pads with no pull change every cycle.
  always_ff @(posedge clk_in)
  begin
    float_ff <= ~float_ff;
  end

  // ========
  // Pad resolution: device drive, then host, then pulls.
  always_comb
  begin
    for (int i = 0; i < 4; i++)
    begin
      if (pad_oe_in[i])
        lvl[i] = pad_out_in[i];
      else if (host_en_in[i])
        lvl[i] = host_val_in[i];
      else if (pull_up_in[i])
        lvl[i] = 1'b1;
      else if (pull_dn_in[i])
        lvl[i] = 1'b0;
      else
        lvl[i] = float_ff[i];
    end
  end

  assign pad_level_out = lvl;
endmodule

// ===== dv/slb_strap_latch_tb.sv
// Bench for the strap latch: power cycles, strap decode, APB access.
// Assumes the board model resolves pads; 125 MHz clock, reset 8 cycles.
`timescale 1ns/1ps

module slb_strap_latch_tb;
  import slb_pkg::*;

  logic        core_clk_in = 1'b0;
  logic        rst_n_in = 1'b0;
  logic        pin = 1'b0;
  logic [3:0]  host_en = 4'hF;
  logic [3:0]  host_val = 4'h0;
  logic [4:0]  fuse = 5'h00;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  slb_straps_t pad_lvl;
  slb_straps_t straps;
  logic [3:0]  pad_out;
  logic [3:0]  pad_oe;
  logic [3:0]  pull_up;
  logic [3:0]  pull_dn;
  logic        active;
  logic        valid;
  logic        v18;
  logic        rom;
  slb_boot_t   boot;
  slb_dbg_t    dbg;
  int          err_count = 0;
  int          comparisons = 0;
  int          cyc = 0;
  int          n;
  logic [31:0] rd;
  logic        rerr;

  slb_strap_latch i_slb_strap_latch (
    .core_clk_in(core_clk_in), .rst_n_in(rst_n_in),
    .power_up_reset_pin_in(pin), .strap_pad_in(pad_lvl),
    .strap_pad_out(pad_out), .strap_pad_oe_out(pad_oe),
    .strap_pull_up_out(pull_up), .strap_pull_dn_out(pull_dn),
    .flash_supply_override_fuse_in(fuse[1]),
    .flash_supply_tieh_fuse_in(fuse[0]), .dbg_dis_pad_fuse_in(fuse[4]),
    .dbg_dis_usb_fuse_in(fuse[3]), .dbg_strap_sel_fuse_in(fuse[2]),
    .chip_active_out(active), .config_valid_out(valid),
    .straps_out(straps), .boot_mode_out(boot),
    .flash_supply_1v8_out(v18), .rom_msg_sel_out(rom),
    .dbg_src_out(dbg), .psel_in(psel), .penable_in(penable),
    .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr));

  slb_board_model i_slb_board_model (
    .clk_in(core_clk_in), .host_en_in(host_en), .host_val_in(host_val),
    .pad_out_in(pad_out), .pad_oe_in(pad_oe), .pull_up_in(pull_up),
    .pull_dn_in(pull_dn), .pad_level_out(pad_lvl));

  // ========
  // Clock and hang guard.
  initial
  begin
    forever #4 core_clk_in = ~core_clk_in;
  end

  always @(posedge core_clk_in)
  begin
    cyc <= cyc + 1;
    if (cyc == 12000)
    begin
      err_count++;
      conclude();
    end
  end

  // ========
  // Shared tasks.
  task automatic conclude();
    $display("errors %0d comparisons %0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      err_count++;
      $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge core_clk_in);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk_in);
    penable <= 1'b1;
    do
      @(posedge core_clk_in);
    while (pready !== 1'b1);
    rd = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  function automatic logic [31:0] exp_dbg(input logic [3:0] s,
                                          input logic [4:0] f);
    case (f[4:3])
      2'h0: return (f[2] && !s[3]) ? 32'(DBG_PADS) : 32'(DBG_USB);
      2'h1: return 32'(DBG_PADS);
      2'h2: return 32'(DBG_USB);
      default: return 32'(DBG_OFF);
    endcase
  endfunction

  task automatic power_up(input logic [3:0] en, input logic [3:0] val,
                          input logic [4:0] f, input int low);
    logic [3:0] s;
    logic [1:0] eb;
    logic [1:0] ed;
    s = (val & en) | (~en & 4'h1);
    eb = s[0] ? 2'(BOOT_FLASH) :
         (s[1] ? 2'(BOOT_INVALID) : 2'(BOOT_DOWNLOAD));
    ed = 2'(exp_dbg(s, f));
    @(posedge core_clk_in);
    pin <= 1'b0;
    repeat (2) @(posedge core_clk_in);
    check(32'(valid), 32'h0);
    check(32'(active), 32'h0);
    repeat (low) @(posedge core_clk_in);
    host_en <= en;
    host_val <= val;
    fuse <= f;
    pin <= 1'b1;
    n = 0;
    do
    begin
      @(posedge core_clk_in);
      #1;
      n++;
      if (n == 60)
        check(32'({pull_up, pull_dn}), 32'h16);
    end
    while (valid !== 1'b1 && n < 300);
    check(n, 126);
    check(32'(active), 32'h1);
    check(32'(straps), 32'(s));
    check(32'(boot), 32'(eb));
    check(32'(v18), f[1] ? 32'(!f[0]) : 32'(s[2]));
    check(32'(rom), 32'(s[1]));
    check(32'(dbg), 32'(ed));
    check(32'({pull_up, pull_dn}), 32'h0);
    host_val <= ~val;
    repeat (3) @(posedge core_clk_in);
    check(32'({straps, boot, dbg}), 32'({s, eb, ed}));
  endtask

  // ========
  // Main sequence.
  initial
  begin
    repeat (8) @(posedge core_clk_in);
    rst_n_in <= 1'b1;
    check(32'({straps, pull_up, pull_dn}), 32'h116);
    power_up(4'h8, 4'h0, 5'h00, 6250);
    for (int k = 0; k < 16; k++)
      power_up(4'hF, k[3:0], 5'(k * 13), 4);
    host_en <= 4'h0;
    apb(1'b1, REG_GPIO_OUT, 32'h0000_000A);
    apb(1'b1, REG_GPIO_OE, 32'h0000_000F);
    apb(1'b0, REG_GPIO_OUT, ZERO_WORD);
    check(rd, 32'h0000_000A);
    apb(1'b0, REG_GPIO_OE, ZERO_WORD);
    check(rd, 32'h0000_000F);
    check(32'({pad_oe, pad_out}), 32'hFA);
    apb(1'b0, REG_GPIO_IN, ZERO_WORD);
    check(rd, 32'h0000_000A);
    apb(1'b1, REG_STATUS, ZERO_WORD);
    apb(1'b0, REG_STATUS, ZERO_WORD);
    check(rd, (32'h1 << ST_VALID_BIT) | 32'h0000_000F);
    apb(1'b1, 8'h10, 32'h0000_0005);
    check(32'(rerr), 32'h1);
    apb(1'b0, 8'h10, ZERO_WORD);
    check({rd[30:0], rerr}, 32'h1);
    apb(1'b0, REG_GPIO_OUT, ZERO_WORD);
    check(rd, 32'h0000_000A);
    conclude();
  end
endmodule
